// ==== hw/tdsr_map.vh ====
`ifndef TDSR_MAP_VH
`define TDSR_MAP_VH

// Register indices
`define TDSR_IDX_OSC_CELL     8'h09
`define TDSR_IDX_OSC_WIRE     8'h0a
`define TDSR_IDX_MEM_SIZE     8'h0c
`define TDSR_IDX_SAVED_SR     8'h10
`define TDSR_IDX_SAVED_PC     8'h11
`define TDSR_IDX_SAVED_SP     8'h12
`define TDSR_IDX_RR_THREAD    8'h13
`define TDSR_IDX_RR_REG       8'h14
`define TDSR_IDX_CAUSE        8'h15
`define TDSR_IDX_PAYLOAD      8'h16
`define TDSR_IDX_HALT_VEC     8'h18

// Saved status word layout
`define TDSR_SR_W             11
`define TDSR_SR_EVENT_EN      0
`define TDSR_SR_IRQ_EN        1
`define TDSR_SR_IN_ENABLE     2
`define TDSR_SR_IN_HANDLER    3
`define TDSR_SR_KERNEL        4
`define TDSR_SR_PAUSED        6
`define TDSR_FAST_ISSUE_FLAG          7
`define TDSR_SR_ISSUE_MODE    8
`define TDSR_SR_KENTRY_ISSUE  9
`define TDSR_SR_ASID          10
// Writable bits of the saved status word: 10,9,7,6,4..0
`define TDSR_SR_WR_MASK       11'h6df

// Field widths and positions
`define TDSR_OSC_W            16
`define TDSR_THR_W            8
`define TDSR_REGSEL_W         5
`define TDSR_CAUSE_W          3
`define TDSR_CAUSE_LSB        0
`define TDSR_CTHR_LSB         8
`define TDSR_BPNUM_LSB        16
`define TDSR_BPNUM_W          2
`define TDSR_MEM_LSB          2

// Cause codes
`define TDSR_CAUSE_NONE       3'h0
`define TDSR_CAUSE_HOST       3'h1
`define TDSR_CAUSE_DEBUG_CALL_INSTR      3'h2
`define TDSR_CAUSE_IBREAK     3'h3
`define TDSR_CAUSE_DWATCH     3'h4
`define TDSR_CAUSE_RWATCH     3'h5

// Reset values
`define TDSR_ZERO32           32'h0000_0000
`define TDSR_RST_SR           11'h000
`define TDSR_RST_THR          8'h00
`define TDSR_RST_REGSEL       5'h00
`define TDSR_RST_BPNUM        2'h0

`endif

// ==== hw/tdsr_osc_cnt.v ====
`include "tdsr_map.vh"

// Oscillator counter, holds its value through system reset
module tdsr_osc_cnt #(
    parameter W = `TDSR_OSC_W
) (
    input  wire         ref_clk,
    input  wire         osc_run,
    input  wire         osc_tick,
    output wire [W-1:0] count
);
    reg [W-1:0] count_r = {W{1'b0}};   // Power-up zero, untouched by system reset

    // Count ticks while running; no reset on purpose
    always @(posedge ref_clk)
    begin
        if (osc_run && osc_tick)
        begin
            count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign count = count_r;
endmodule

// ==== hw/tdsr_cause_enc.v ====
`include "tdsr_map.vh"

// Derives thread and hit number fields from the entry cause
module tdsr_cause_enc #(
    parameter THR_W = `TDSR_THR_W
) (
    input  wire [2:0]       cause,
    input  wire [THR_W-1:0] thread_in,
    input  wire [3:0]       hit_vec,
    output reg  [THR_W-1:0] thread_out,
    output reg  [1:0]       hit_num
);
    // Lowest set hit wins
    function [1:0] lowest_hit;
        input [3:0] v;
        begin
            if (v[0])
                lowest_hit = 2'h0;
            else if (v[1])
                lowest_hit = 2'h1;
            else if (v[2])
                lowest_hit = 2'h2;
            else if (v[3])
                lowest_hit = 2'h3;
            else
                lowest_hit = 2'h0;
        end
    endfunction

    // Host and call entries carry no hit number; host carries no thread
    always @*
    begin
        thread_out = thread_in;
        hit_num    = lowest_hit(hit_vec);
        if (cause == `TDSR_CAUSE_HOST)
        begin
            thread_out = `TDSR_RST_THR;
            hit_num    = `TDSR_RST_BPNUM;
        end
        else if (cause == `TDSR_CAUSE_DEBUG_CALL_INSTR)
        begin
            hit_num    = `TDSR_RST_BPNUM;
        end
    end
endmodule

// ==== hw/tdsr_top.v ====
`include "tdsr_map.vh"

module tdsr_top #(
    parameter [31:0] RAM_BYTES = 32'h0001_0000,
    parameter        THR_W     = `TDSR_THR_W,
    parameter        OSC_W     = `TDSR_OSC_W
) (
    input  wire             ref_clk,
    input  wire             sys_rst,
    // Register port
    input  wire [7:0]       reg_addr,
    input  wire             reg_wr,
    input  wire             reg_rd,
    input  wire [31:0]      reg_wdata,
    output wire [31:0]      reg_rdata,
    output wire             reg_rvalid,
    // Debug state
    input  wire             debug_mode,
    input  wire             debug_entry,
    input  wire [10:0]      thread_status_word,
    input  wire [31:0]      saved_program_counter,
    input  wire [31:0]      saved_stack_pointer,
    input  wire [2:0]       entry_cause,
    input  wire [THR_W-1:0] entry_thread,
    input  wire [3:0]       entry_hit_vec,
    input  wire [31:0]      entry_data_addr,
    input  wire [31:0]      entry_resource_id,
    // Oscillators
    input  wire             osc_cell_run,
    input  wire             osc_cell_tick,
    input  wire             osc_wire_run,
    input  wire             osc_wire_tick,
    // Thread stop outputs
    output wire [THR_W-1:0] thread_stop
);
    reg  [10:0]              saved_sr_r;
    reg  [10:0]              saved_sr_nxt;
    reg  [31:0]              saved_pc_r;
    reg  [31:0]              saved_sp_r;
    reg  [THR_W-1:0]         rr_thread_r;
    reg  [`TDSR_REGSEL_W-1:0] rr_reg_r;
    reg  [2:0]               cause_r;
    reg  [THR_W-1:0]         cause_thr_r;
    reg  [1:0]               hit_num_r;
    reg  [31:0]              payload_r;
    reg  [THR_W-1:0]         halt_vec_r;
    reg  [THR_W-1:0]         stop_r;
    reg  [31:0]              rdata_r;
    reg  [31:0]              rdata_nxt;
    reg                      rvalid_r;
    wire [OSC_W-1:0]         cell_count;
    wire [OSC_W-1:0]         wire_count;
    wire [THR_W-1:0]         enc_thread;
    wire [1:0]               enc_hit;
    wire                     dbg_wr;

    // Writes to debug-writable fields only in debug mode
    assign dbg_wr = reg_wr & debug_mode;

    // Address match helper
    function hit;
        input [7:0] a;
        input [7:0] idx;
        begin
            hit = (a == idx);
        end
    endfunction

    // Peripheral cell and wire oscillator counters
    tdsr_osc_cnt #(
        .W        (OSC_W)
    ) u_osc_cell (
        .ref_clk  (ref_clk),
        .osc_run  (osc_cell_run),
        .osc_tick (osc_cell_tick),
        .count    (cell_count)
    );

    tdsr_osc_cnt #(
        .W        (OSC_W)
    ) u_osc_wire (
        .ref_clk  (ref_clk),
        .osc_run  (osc_wire_run),
        .osc_tick (osc_wire_tick),
        .count    (wire_count)
    );

    // Cause field derivation
    tdsr_cause_enc #(
        .THR_W      (THR_W)
    ) u_cause_enc (
        .cause      (entry_cause),
        .thread_in  (entry_thread),
        .hit_vec    (entry_hit_vec),
        .thread_out (enc_thread),
        .hit_num    (enc_hit)
    );

    // Saved status next value; bits 8 and 5 kept read-only
    always @*
    begin
        saved_sr_nxt = saved_sr_r;
        if (dbg_wr && hit(reg_addr, `TDSR_IDX_SAVED_SR))
        begin
            saved_sr_nxt = (saved_sr_r & ~`TDSR_SR_WR_MASK)
                         | (reg_wdata[`TDSR_SR_W-1:0] & `TDSR_SR_WR_MASK);
        end
        if (debug_entry)
        begin
            saved_sr_nxt = thread_status_word;
        end
    end

    // Saved status register
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            saved_sr_r <= `TDSR_RST_SR;
        end
        else
        begin
            saved_sr_r <= saved_sr_nxt;
        end
    end

    // Saved program counter and stack pointer; capture beats writes
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            saved_pc_r <= `TDSR_ZERO32;
            saved_sp_r <= `TDSR_ZERO32;
        end
        else if (debug_entry)
        begin
            saved_pc_r <= saved_program_counter;
            saved_sp_r <= saved_stack_pointer;
        end
        else
        begin
            if (dbg_wr && hit(reg_addr, `TDSR_IDX_SAVED_PC))
            begin
                saved_pc_r <= reg_wdata;
            end
            if (dbg_wr && hit(reg_addr, `TDSR_IDX_SAVED_SP))
            begin
                saved_sp_r <= reg_wdata;
            end
        end
    end

    // Register-read operands
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rr_thread_r <= `TDSR_RST_THR;
            rr_reg_r    <= `TDSR_RST_REGSEL;
        end
        else
        begin
            if (dbg_wr && hit(reg_addr, `TDSR_IDX_RR_THREAD))
            begin
                rr_thread_r <= reg_wdata[THR_W-1:0];
            end
            if (dbg_wr && hit(reg_addr, `TDSR_IDX_RR_REG))
            begin
                rr_reg_r <= reg_wdata[`TDSR_REGSEL_W-1:0];
            end
        end
    end

    // Entry cause register; capture beats writes
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cause_r     <= `TDSR_CAUSE_NONE;
            cause_thr_r <= `TDSR_RST_THR;
            hit_num_r   <= `TDSR_RST_BPNUM;
        end
        else if (debug_entry)
        begin
            cause_r     <= entry_cause;
            cause_thr_r <= enc_thread;
            hit_num_r   <= enc_hit;
        end
        else if (dbg_wr && hit(reg_addr, `TDSR_IDX_CAUSE))
        begin
            cause_r     <= reg_wdata[`TDSR_CAUSE_LSB +: `TDSR_CAUSE_W];
            cause_thr_r <= reg_wdata[`TDSR_CTHR_LSB +: THR_W];
            hit_num_r   <= reg_wdata[`TDSR_BPNUM_LSB +: `TDSR_BPNUM_W];
        end
    end

    // Entry payload; only watchpoint entries load it
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            payload_r <= `TDSR_ZERO32;
        end
        else if (debug_entry && entry_cause == `TDSR_CAUSE_DWATCH)
        begin
            payload_r <= entry_data_addr;
        end
        else if (debug_entry && entry_cause == `TDSR_CAUSE_RWATCH)
        begin
            payload_r <= entry_resource_id;
        end
        else if (dbg_wr && hit(reg_addr, `TDSR_IDX_PAYLOAD))
        begin
            payload_r <= reg_wdata;
        end
    end

    // Halt vector and thread stop outputs
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            halt_vec_r <= `TDSR_RST_THR;
            stop_r     <= `TDSR_RST_THR;
        end
        else
        begin
            if (dbg_wr && hit(reg_addr, `TDSR_IDX_HALT_VEC))
            begin
                halt_vec_r <= reg_wdata[THR_W-1:0];
            end
            stop_r <= debug_mode ? `TDSR_RST_THR : halt_vec_r;
        end
    end

    // Read data selection; unmapped indices read zero
    always @*
    begin
        rdata_nxt = `TDSR_ZERO32;
        case (reg_addr)
            `TDSR_IDX_OSC_CELL:
                rdata_nxt[OSC_W-1:0] = cell_count;
            `TDSR_IDX_OSC_WIRE:
                rdata_nxt[OSC_W-1:0] = wire_count;
            `TDSR_IDX_MEM_SIZE:
                rdata_nxt[31:`TDSR_MEM_LSB] = RAM_BYTES[31:`TDSR_MEM_LSB];
            `TDSR_IDX_SAVED_SR:
                rdata_nxt[`TDSR_SR_W-1:0] = saved_sr_r;
            `TDSR_IDX_SAVED_PC:
                rdata_nxt = saved_pc_r;
            `TDSR_IDX_SAVED_SP:
                rdata_nxt = saved_sp_r;
            `TDSR_IDX_RR_THREAD:
                rdata_nxt[THR_W-1:0] = rr_thread_r;
            `TDSR_IDX_RR_REG:
                rdata_nxt[`TDSR_REGSEL_W-1:0] = rr_reg_r;
            `TDSR_IDX_CAUSE:
            begin
                rdata_nxt[`TDSR_CAUSE_LSB +: `TDSR_CAUSE_W] = cause_r;
                rdata_nxt[`TDSR_CTHR_LSB +: THR_W]          = cause_thr_r;
                rdata_nxt[`TDSR_BPNUM_LSB +: `TDSR_BPNUM_W] = hit_num_r;
            end
            `TDSR_IDX_PAYLOAD:
                rdata_nxt = payload_r;
            `TDSR_IDX_HALT_VEC:
                rdata_nxt[THR_W-1:0] = halt_vec_r;
            default:
                rdata_nxt = `TDSR_ZERO32;
        endcase
    end

    // Registered read answer, valid one cycle after request
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rdata_r  <= `TDSR_ZERO32;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= reg_rd;
            if (reg_rd)
            begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign reg_rdata   = rdata_r;
    assign reg_rvalid  = rvalid_r;
    assign thread_stop = stop_r;
endmodule

// ==== sim/tdsr_props.sv ====
module tdsr_props #(
    parameter [31:0] RAM_BYTES = 32'h0001_0000
) (
    input logic        ref_clk,
    input logic        sys_rst,
    input logic [7:0]  reg_addr,
    input logic        reg_rd,
    input logic [31:0] reg_rdata,
    input logic        reg_rvalid,
    input logic        debug_mode,
    input logic        debug_entry,
    input logic [2:0]  entry_cause,
    input logic [7:0]  thread_stop
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // Capture then immediate read of the cause register
    sequence s_cause_read;
        debug_entry ##1 (reg_rd && reg_addr == 8'h15);
    endsequence
    sequence s_host_read;
        debug_entry && entry_cause == 3'h1 ##1 (reg_rd && reg_addr == 8'h15);
    endsequence
    // Register port answers and holds
    a_read_answered: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_rvalid_has_read: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("answer without read");
    a_rdata_holds: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved");
    a_stop_in_debug: assert property (debug_mode |=> thread_stop == 8'h00)
        else $error("thread held in debug mode");
    a_osc_upper_zero: assert property (reg_rvalid && ($past(reg_addr) == 8'h09 || $past(reg_addr) == 8'h0a)
        |-> reg_rdata[31:16] == 16'h0000)
        else $error("count upper bits set");
    a_mem_size_value: assert property (reg_rvalid && $past(reg_addr) == 8'h0c
        |-> reg_rdata == {RAM_BYTES[31:2], 2'h0})
        else $error("memory size wrong");
    a_status_upper_zero: assert property (reg_rvalid && $past(reg_addr) == 8'h10
        |-> reg_rdata[31:11] == 21'h000000)
        else $error("status upper bits set");
    a_entry_cause_code: assert property (s_cause_read |=> reg_rdata[2:0] == $past(entry_cause, 2))
        else $error("cause code not captured");
    a_host_thread_zero: assert property (s_host_read |=> reg_rdata[17:8] == 10'h000)
        else $error("host entry fields not zero");
endmodule

bind tdsr_top tdsr_props #(.RAM_BYTES(RAM_BYTES)) u_props (.ref_clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata,
    .reg_rvalid, .debug_mode, .debug_entry, .entry_cause, .thread_stop);

// ==== sim/tdsr_osc_src.sv ====
module tdsr_osc_src (
    input  logic ref_clk,
    output logic run,
    output logic tick
);
    timeunit 1ns;
    timeprecision 1ps;
    // Oscillator idle at start
    initial
    begin
        run = 1'b0;
        tick = 1'b0;
    end
    // Counts n cycles, then stays stopped before any read
    task automatic burst(input int n);
        @(posedge ref_clk);
        #1 run = 1'b1;
        tick = 1'b1;
        repeat (n) @(posedge ref_clk);
        #1 run = 1'b0;
        tick = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
    endtask
endmodule

// ==== sim/tdsr_top_test.sv ====
module tdsr_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        debug_mode = 1'b0, debug_entry = 1'b0;
    logic [7:0]  reg_addr = 8'h00, entry_thread = 8'h00;
    logic [31:0] reg_wdata = 32'h0, saved_program_counter = 32'h0, saved_stack_pointer = 32'h0;
    logic [31:0] entry_data_addr = 32'h0, entry_resource_id = 32'h0;
    logic [10:0] thread_status_word = 11'h000;
    logic [2:0]  entry_cause = 3'h0;
    logic [3:0]  entry_hit_vec = 4'h0;
    wire  [31:0] reg_rdata;
    wire         reg_rvalid, osc_cell_run, osc_cell_tick, osc_wire_run, osc_wire_tick;
    wire  [7:0]  thread_stop;
    int          bad_count = 0, compares = 0;
    logic [7:0]  ra [8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18};
    logic [31:0] rm [8] = '{32'h6df, 32'hffffffff, 32'hffffffff, 32'hff, 32'h1f, 32'h3ff07, 32'hffffffff, 32'hff};

    // Core clock
    always #2 ref_clk = ~ref_clk;

    tdsr_top DUT (.ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
        .debug_mode, .debug_entry, .thread_status_word, .saved_program_counter, .saved_stack_pointer,
        .entry_cause, .entry_thread, .entry_hit_vec, .entry_data_addr, .entry_resource_id,
        .osc_cell_run, .osc_cell_tick, .osc_wire_run, .osc_wire_tick, .thread_stop);
    tdsr_osc_src osc_c (.ref_clk, .run(osc_cell_run), .tick(osc_cell_tick));
    tdsr_osc_src osc_w (.ref_clk, .run(osc_wire_run), .tick(osc_wire_tick));

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #1 reg_wr = 1'b0;
        // Let one edge pass so a following write never re-raises the strobe in this step
        @(posedge ref_clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int n;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        #1 reg_rd = 1'b0;
        for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++)
        begin
            @(posedge ref_clk);
            #1;
        end
        if (n == 4)
        begin
            bad_count++;
            wrap_up();
        end
        d = reg_rdata;
        // Gap before the next request
        @(posedge ref_clk);
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    // Expected cause word: code, raising thread, lowest hit number
    function automatic logic [31:0] cause_exp(input logic [2:0] c, input logic [7:0] t, input logic [3:0] v);
        logic [1:0] h;
        h = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : v[3] ? 2'h3 : 2'h0;
        if (c < 3'h3)
            h = 2'h0;
        if (c == 3'h1)
            t = 8'h00;
        return {14'h0, h, t, 5'h0, c};
    endfunction

    // Main sequence
    initial
    begin
        logic [31:0] d, c0, c1, w0, pay;
        int n;
        void'($urandom(32'hb2366700));
        repeat (5) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        foreach (ra[i]) wr(ra[i], $urandom);
        foreach (ra[i]) rchk(ra[i], 32'h0);
        debug_mode = 1'b1;
        foreach (ra[i])
        begin
            d = $urandom;
            wr(ra[i], d);
            rchk(ra[i], d & rm[i]);
            if (ra[i] == 8'h16)
                pay = d;
        end
        wr(8'h0c, $urandom);
        wr(8'h20, $urandom);
        rchk(8'h0c, 32'h0001_0000);
        rchk(8'h20, 32'h0);
        rd(8'h09, d);
        chk(d[31:16], 32'h0);
        $display("test registers done");
        for (n = 0; n < 10; n++)
        begin
            entry_cause = 3'(n % 5 + 1);
            entry_thread = 8'($urandom);
            entry_hit_vec = (n == 2) ? 4'h0 : 4'($urandom);
            thread_status_word = 11'($urandom);
            saved_program_counter = $urandom;
            saved_stack_pointer = $urandom;
            entry_data_addr = $urandom;
            entry_resource_id = $urandom;
            debug_entry = 1'b1;
            @(posedge ref_clk);
            #1 debug_entry = 1'b0;
            rchk(8'h15, cause_exp(entry_cause, entry_thread, entry_hit_vec));
            if (entry_cause == 3'h4)
                pay = entry_data_addr;
            if (entry_cause == 3'h5)
                pay = entry_resource_id;
            rchk(8'h16, pay);
            rchk(8'h10, {21'h0, thread_status_word});
            rchk(8'h11, saved_program_counter);
            rchk(8'h12, saved_stack_pointer);
        end
        $display("test entries done");
        d = $urandom & 32'hff;
        wr(8'h18, d);
        debug_mode = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk(thread_stop, d);
        wr(8'h18, ~d);
        rchk(8'h18, d);
        debug_mode = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 chk(thread_stop, 32'h0);
        $display("test halt done");
        rd(8'h09, c0);
        rd(8'h0a, w0);
        n = $urandom_range(40, 1);
        osc_c.burst(n);
        rd(8'h09, c1);
        chk(c1, (c0 + n) & 32'hffff);
        rchk(8'h0a, w0);
        osc_w.burst(n);
        rd(8'h0a, d);
        chk(d, (w0 + n) & 32'hffff);
        sys_rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        rchk(8'h09, c1);
        rchk(8'h11, 32'h0);
        $display("test counters done");
        wrap_up();
    end
endmodule
